// [logic/tape_char_class.sv]
// Classifier for one incoming tape character.
`timescale 1ns/10ps
`default_nettype none
`include "tape_load_defines.svh"
module tape_char_class (
  input wire logic [7:0] i_char,  // Received character
  output logic o_blank,           // Blank tape
  output logic o_stop,            // Channel 7 punched
  output logic o_digit,           // Loader octal digit
  output logic [2:0] o_group      // Three data bits
);
  // Stop takes precedence over any digit decode
  assign o_stop = i_char[`STOP_BIT];
  assign o_blank = (i_char == `BLANK_CODE);
  // Both high and plain codes carry a digit
  assign o_digit = !o_stop &&
    (((i_char & `LOADER_MASK) == `LOADER_HI_CODE) ||
     ((i_char & `LOADER_MASK) == `LOADER_LO_CODE));
  assign o_group = i_char[2:0];
endmodule
`default_nettype wire

// [logic/tape_load_defines.svh]
// Constants for the tape load-mode packer.
`ifndef TAPE_LOAD_DEFINES_SVH
`define TAPE_LOAD_DEFINES_SVH
`define WORD_W 12
`define CHAR_W 8
`define ADDR_W 13
`define GROUP_W 3
`define GROUPS_PER_WORD 3'h4
`define LOADER_HI_CODE 8'hb0
`define LOADER_LO_CODE 8'h10
`define LOADER_MASK 8'hf8
`define STOP_BIT 6
`define BLANK_CODE 8'h00
`define SECTOR_BITS 7
`define CLK_HZ 200000000
`define CHAR_RATE_HZ 10
`endif

// [logic/tape_load_mode_packer.sv]
// Load-mode packer and programmed character transfer path.
// Summary of operation
// - Four successive loader characters build one word, then write and advance.
// - Only three data bits are kept from each accepted loader character.
// - Loader digits are codes 260-267 or 020-027 octal.
// - Blank tape is discarded in load mode with no count change.
// - Load mode ends only on a stop character, never on blanks.
// - Any character with channel 7 punched is a stop character.
// - Relocation: two characters give sector bits 1-3 then 4-6, then stop.
// - Programmed input places the character in accumulator low eight bits.
// - Characters go to the terminal only by programmed output.
// - Input and output transfers can raise interrupt requests.
// - Only an on-line terminal starts a transfer; off-line, only an already pending output can still leave.
`timescale 1ns/10ps
`default_nettype none
`include "tape_load_defines.svh"
module tape_load_mode_packer #(
  parameter int WORD_W = `WORD_W,
  parameter int ADDR_W = `ADDR_W
) (
  input wire logic i_ref_clk,               // 200 MHz clock
  input wire logic i_rst_b,                 // Sync reset, active low
  input wire logic i_online,                // Terminal on-line
  input wire logic i_load_en,               // Load switch on
  input wire logic i_reloc_en,              // Next load uses relocation
  input wire logic i_start,                 // Start pulse
  input wire logic [ADDR_W-1:0] i_pc,       // Start address from host
  input wire logic i_rx_valid,              // Terminal character strobe
  input wire logic [7:0] i_rx_char,         // Terminal character
  input wire logic i_rd_req,                // Programmed input pulse
  input wire logic i_wr_req,                // Programmed output pulse
  input wire logic [7:0] i_wr_char,         // Programmed output data
  input wire logic i_tx_ready,              // Terminal accepts character
  input wire logic i_rx_ie,                 // Input interrupt enable
  input wire logic i_tx_ie,                 // Output interrupt enable
  output logic o_mem_we,                    // Memory write pulse
  output logic [ADDR_W-1:0] o_mem_addr,     // Memory write address
  output logic [WORD_W-1:0] o_mem_data,     // Memory write data
  output logic o_load_busy,                 // Load mode active
  output logic o_load_done,                 // Stop seen pulse
  output logic [ADDR_W-1:0] o_pc,           // Current load address
  output logic [WORD_W-1:0] o_acc,          // Accumulator image
  output logic o_rx_full,                   // Input character waiting
  output logic o_tx_valid,                  // Character to terminal
  output logic [7:0] o_tx_char,             // Character to terminal
  output logic o_tx_busy,                   // Output in progress
  output logic o_irq                        // Interrupt request
);
  import tape_load_pkg::*;

  load_state_t state_reg;
  logic [WORD_W-1:0] shift_reg;
  logic [2:0] count_reg;
  logic [ADDR_W-1:0] pc_reg;
  logic [5:0] sector_reg;
  logic reloc_second_reg;
  logic [7:0] rx_buf_reg;
  logic rx_full_reg;
  logic [7:0] tx_reg;
  logic tx_pending_reg;
  logic tx_done_reg;
  logic c_blank;
  logic c_stop;
  logic c_digit;
  logic [2:0] c_group;
  logic char_in;
  logic in_load;
  logic [WORD_W-1:0] word_next;
  logic start_take;
  logic digit_take;
  logic word_end;
  logic reloc_digit;
  logic reloc_stop;
  logic load_stop;
  logic prog_take;
  logic tx_take;
  logic tx_leave;
  logic [2:0] sector_slot [0:1];
  logic irq_rx;
  logic irq_tx;

  tape_char_class u_class (
    .i_char(i_rx_char),
    .o_blank(c_blank),
    .o_stop(c_stop),
    .o_digit(c_digit),
    .o_group(c_group)
  );

  // Off-line terminal contributes nothing
  assign char_in = i_rx_valid && i_online;
  assign in_load = (state_reg == ST_LOAD) || (state_reg == ST_RELOC);
  // New group enters at the bottom, so the first ends up on top
  assign word_next = {shift_reg[WORD_W-4:0], c_group};

  // Named strobes, so each process reads one agreed condition
  assign start_take = (state_reg == ST_IDLE) && i_start && i_load_en;
  // Only a decoded digit counts; blanks and others fall out here
  assign digit_take = (state_reg == ST_LOAD) && char_in && c_digit &&
    !c_blank;
  assign word_end = digit_take &&
    (count_reg == `GROUPS_PER_WORD - 3'h1);
  // Relocation path: sector digits, then the stop that applies them
  assign reloc_digit = (state_reg == ST_RELOC) && char_in && c_digit;
  assign reloc_stop = (state_reg == ST_RELOC) && char_in && c_stop;
  // Blank runs never reach here, only a channel 7 punch does
  assign load_stop = (state_reg == ST_LOAD) && char_in && c_stop;
  // Load mode owns the reader, so no buffering while it runs
  assign prog_take = char_in && !in_load;
  // A busy or off-line printer refuses the write outright
  assign tx_take = i_wr_req && !tx_pending_reg && i_online;
  assign tx_leave = tx_pending_reg && i_tx_ready;

  // Load sequencer; no timeout, the tape pace is slow and unbounded
  // Digits never move the state; starts and stops do, and done returns to idle
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      state_reg <= ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (i_start && i_load_en) begin
            state_reg <= i_reloc_en ? ST_RELOC : ST_LOAD;
          end
        end
        ST_RELOC: begin
          if (char_in && c_stop) begin
            state_reg <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          if (char_in && c_stop) begin
            state_reg <= ST_DONE;
          end
        end
        ST_DONE: begin
          state_reg <= ST_IDLE;
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Word assembly from digit groups
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      shift_reg <= '0;
      count_reg <= 3'h0;
    end else if (state_reg != ST_LOAD) begin
      count_reg <= 3'h0;
    end else if (digit_take) begin
      shift_reg <= word_next;
      if (word_end) begin
        count_reg <= 3'h0;
      end else begin
        count_reg <= count_reg + 3'h1;
      end
    end
  end

  // Memory write on the fourth group
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      o_mem_we <= 1'b0;
      o_mem_addr <= '0;
      o_mem_data <= '0;
    end else begin
      o_mem_we <= 1'b0;
      if (word_end) begin
        o_mem_we <= 1'b1;
        o_mem_addr <= pc_reg;
        o_mem_data <= word_next;
      end
    end
  end

  // Load address; host gives a sector-aligned start
  // Relocation replaces it with the sector base before any data
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      pc_reg <= '0;
    end else if (start_take) begin
      pc_reg <= i_pc;
    end else if (reloc_stop) begin
      pc_reg <= {sector_reg, {`SECTOR_BITS{1'b0}}};
    end else if (word_end) begin
      pc_reg <= pc_reg + 1'b1;
    end
  end

  // Relocation turn: cleared outside, set after the first digit
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      reloc_second_reg <= 1'b0;
    end else if (state_reg != ST_RELOC) begin
      reloc_second_reg <= 1'b0;
    end else if (reloc_digit) begin
      reloc_second_reg <= 1'b1;
    end
  end

  // One sector slot per relocation digit: first is low bits, second
  // high; a stray third digit overwrites the high slot
  for (genvar s = 0; s < 2; s++) begin : g_sector
    always_ff @(posedge i_ref_clk) begin
      if (!i_rst_b) begin
        sector_slot[s] <= 3'h0;
      end else if (reloc_digit && (reloc_second_reg == (s != 0))) begin
        sector_slot[s] <= c_group;
      end
    end
  end
  assign sector_reg = {sector_slot[1], sector_slot[0]};

  // Input character register; load mode owns the reader while active
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      rx_buf_reg <= 8'h00;
    end else if (prog_take) begin
      rx_buf_reg <= i_rx_char;
    end
  end

  // Input waiting flag; an arrival wins over a read in the same cycle
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      rx_full_reg <= 1'b0;
    end else if (prog_take) begin
      rx_full_reg <= 1'b1;
    end else if (i_rd_req) begin
      rx_full_reg <= 1'b0;
    end
  end

  // Accumulator low eight bits take the character
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      o_acc <= '0;
    end else if (i_rd_req && rx_full_reg) begin
      o_acc <= {{(WORD_W-8){1'b0}}, rx_buf_reg};
    end
  end

  // Output character; captured once, held until the terminal takes it
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      tx_reg <= 8'h00;
    end else if (tx_take) begin
      tx_reg <= i_wr_char;
    end
  end

  // Output pending; the slow printer may take many cycles to answer
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      tx_pending_reg <= 1'b0;
    end else if (tx_take) begin
      tx_pending_reg <= 1'b1;
    end else if (tx_leave) begin
      tx_pending_reg <= 1'b0;
    end
  end

  // Output done flag for the interrupt; a new write clears it
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      tx_done_reg <= 1'b0;
    end else if (tx_leave) begin
      tx_done_reg <= 1'b1;
    end else if (tx_take) begin
      tx_done_reg <= 1'b0;
    end
  end

  // Stop pulse and status
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      o_load_done <= 1'b0;
    end else begin
      o_load_done <= load_stop;
    end
  end

  // Status straight from the registers
  assign o_load_busy = in_load;
  assign o_pc = pc_reg;
  assign o_rx_full = rx_full_reg;
  assign o_tx_valid = tx_pending_reg;
  assign o_tx_char = tx_reg;
  assign o_tx_busy = tx_pending_reg;
  // Input request while a character waits to be read
  assign irq_rx = i_rx_ie && rx_full_reg;
  // Output request once the last character left and none is pending
  assign irq_tx = i_tx_ie && tx_done_reg && !tx_pending_reg;
  // Level request, held until software reads or writes
  assign o_irq = irq_rx || irq_tx;
endmodule
`default_nettype wire

// [logic/tape_load_pkg.sv]
// Types for the tape load-mode packer.
package tape_load_pkg;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_LOAD = 4'h2,
    ST_RELOC = 4'h4,
    ST_DONE = 4'h8
  } load_state_t;
endpackage

// [verification/tape_load_asserts.sv]
// Port checker for the tape load-mode packer.
`timescale 1ns/10ps
`default_nettype none
module tape_load_asserts #(
  parameter int WORD_W = 12,
  parameter int ADDR_W = 13
) (
  input wire logic i_ref_clk, // Clock
  input wire logic i_rst_b, // Reset
  input wire logic i_online, // On-line
  input wire logic i_rx_valid, // Strobe
  input wire logic [7:0] i_rx_char, // Char
  input wire logic i_rd_req, // Read
  input wire logic i_wr_req, // Write
  input wire logic i_rx_ie, // Rx enable
  input wire logic o_mem_we, // Write
  input wire logic [ADDR_W-1:0] o_mem_addr, // Address
  input wire logic o_load_busy, // Busy
  input wire logic o_load_done, // Done
  input wire logic [ADDR_W-1:0] o_pc, // Load address
  input wire logic [WORD_W-1:0] o_acc, // Acc
  input wire logic o_rx_full, // Waiting
  input wire logic o_tx_valid, // Tx
  input wire logic o_irq // Irq
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);
  // Four digits per word, so a write never lasts two cycles
  a_we_single: assert property (o_mem_we |=> !o_mem_we)
    else $error("write pulse too long");
  a_pc_steps: assert property (o_mem_we |-> o_pc == o_mem_addr + 1'b1)
    else $error("address did not advance");
  a_blank_ignored: assert property (o_load_busy && i_rx_valid
    && i_rx_char == 8'h00 |=> !o_mem_we) else $error("blank stored");
  a_done_cause: assert property (o_load_done |-> !o_load_busy
    && $past(i_rx_valid && i_online && i_rx_char[6]))
    else $error("done without stop");
  a_offline_quiet: assert property (!o_rx_full
    && !(i_rx_valid && i_online) |=> !o_rx_full)
    else $error("input without on-line char");
  a_read_low: assert property (i_rd_req && o_rx_full && !i_rx_valid
    && !o_load_busy |=> !o_rx_full && o_acc[11:8] == 4'h0)
    else $error("read result wrong");
  a_tx_prog: assert property ($rose(o_tx_valid) |-> $past(i_wr_req))
    else $error("output without write");
  a_irq_rx: assert property (i_rx_ie && o_rx_full |-> o_irq)
    else $error("input irq missing");
endmodule
bind tape_load_mode_packer tape_load_asserts #(
  .WORD_W(WORD_W),
  .ADDR_W(ADDR_W)
) chk (
  .i_ref_clk(i_ref_clk),
  .i_rst_b(i_rst_b),
  .i_online(i_online),
  .i_rx_valid(i_rx_valid),
  .i_rx_char(i_rx_char),
  .i_rd_req(i_rd_req),
  .i_wr_req(i_wr_req),
  .i_rx_ie(i_rx_ie),
  .o_mem_we(o_mem_we),
  .o_mem_addr(o_mem_addr),
  .o_load_busy(o_load_busy),
  .o_load_done(o_load_done),
  .o_pc(o_pc),
  .o_acc(o_acc),
  .o_rx_full(o_rx_full),
  .o_tx_valid(o_tx_valid),
  .o_irq(o_irq)
);
`default_nettype wire

// [verification/tape_load_mode_packer_test.sv]
// Self-checking bench for the tape load-mode packer.
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, a) begin n_compared++; if ((a) !== (e)) begin \
  errors++; $display("unexpected %s exp %h got %h", n, e, a); end end
module tape_load_mode_packer_test;
  logic i_ref_clk = 0, i_rst_b = 0, i_online = 1, i_load_en = 0;
  logic i_reloc_en = 0, i_start = 0, i_rd_req = 0, i_wr_req = 0;
  logic i_rx_ie = 0, i_tx_ie = 0, rx_v, tx_r, o_mem_we, o_load_busy;
  logic o_load_done, o_rx_full, o_tx_valid, o_tx_busy, o_irq;
  logic [12:0] i_pc = 0, o_mem_addr, o_pc, wa;
  logic [11:0] o_mem_data, o_acc, wd;
  logic [7:0] rx_c, i_wr_char = 0, o_tx_char;
  int errors = 0, n_compared = 0, wn = 0, dn = 0;
  tape_load_mode_packer dut (.i_ref_clk, .i_rst_b, .i_online,
    .i_load_en, .i_reloc_en, .i_start, .i_pc, .i_rx_valid(rx_v),
    .i_rx_char(rx_c), .i_rd_req, .i_wr_req, .i_wr_char,
    .i_tx_ready(tx_r), .i_rx_ie, .i_tx_ie, .o_mem_we, .o_mem_addr,
    .o_mem_data, .o_load_busy, .o_load_done, .o_pc, .o_acc, .o_rx_full,
    .o_tx_valid, .o_tx_char, .o_tx_busy, .o_irq);
  tape_terminal_model term (.i_ref_clk, .o_rx_valid(rx_v),
    .o_rx_char(rx_c), .i_tx_valid(o_tx_valid), .i_tx_char(o_tx_char),
    .o_tx_ready(tx_r));
  // Clock
  initial forever #2.5 i_ref_clk = ~i_ref_clk;
  // Record writes and stop pulses mid-cycle, while they stand
  always @(negedge i_ref_clk) begin
    if (o_mem_we === 1'b1) begin
      wn++;
      wd = o_mem_data;
      wa = o_mem_addr;
    end
    if (o_load_done === 1'b1) dn++;
  end
  task automatic pulse(ref logic s);
    @(negedge i_ref_clk) s = 1'b1;
    @(negedge i_ref_clk) s = 1'b0;
    @(negedge i_ref_clk);
  endtask
  task automatic sendq(input logic [7:0] q[$]);
    foreach (q[i]) term.send(q[i]);
  endtask
  // Two words, blanks inside, partial word dropped at stop
  task automatic t_load;
    i_load_en = 1;
    i_pc = 13'h0f80;
    pulse(i_start);
    `CHK("busy", 1'b1, o_load_busy)
    sendq('{8'hb0, 8'hb1, 8'h00, 8'hb2, 8'hb3});
    `CHK("word0", 12'h053, wd)
    `CHK("addr0", 13'h0f80, wa)
    sendq('{8'hb4, 8'hb5, 8'hb6, 8'hb7, 8'hb5, 8'hb6, 8'h00, 8'h00});
    `CHK("word1", 12'h977, wd)
    `CHK("pc", 13'h0f82, o_pc)
    `CHK("busy", 1'b1, o_load_busy)
    term.send(8'hc8);
    `CHK("writes", 2, wn)
    `CHK("dones", 1, dn)
    `CHK("idle", 1'b0, o_load_busy)
  endtask
  // Sector from two digits, then a low-set word
  task automatic t_reloc;
    i_reloc_en = 1;
    i_pc = 13'h0000;
    pulse(i_start);
    i_reloc_en = 0;
    sendq('{8'hb3, 8'h00, 8'hb5, 8'h48});
    `CHK("sector", 13'h1580, o_pc)
    sendq('{8'h13, 8'h12, 8'h11, 8'h10, 8'hff});
    `CHK("word2", 12'h688, wd)
    `CHK("addr2", 13'h1580, wa)
    `CHK("dones", 2, dn)
    i_load_en = 0;
  endtask
  // Programmed input and output, off-line refusals
  task automatic t_prog;
    i_rx_ie = 1;
    term.send(8'h41);
    `CHK("irq_rx", 1'b1, o_irq)
    pulse(i_rd_req);
    `CHK("acc", 12'h041, o_acc)
    `CHK("full", 1'b0, o_rx_full)
    i_online = 0;
    term.send(8'h42);
    i_wr_char = 8'h33;
    pulse(i_wr_req);
    `CHK("off_rx", 1'b0, o_rx_full)
    `CHK("off_tx", 1'b0, o_tx_valid)
    i_online = 1;
    i_tx_ie = 1;
    i_wr_char = 8'h5a;
    pulse(i_wr_req);
    `CHK("tx_v", 1'b1, o_tx_valid)
    for (int k = 0; k < 40 && o_tx_valid !== 1'b0; k++)
      @(negedge i_ref_clk);
    `CHK("tx_char", 8'h5a, term.last)
    `CHK("tx_busy", 1'b0, o_tx_busy)
    `CHK("irq_tx", 1'b1, o_irq)
    `CHK("no_write", 3, wn)
  endtask
  task automatic report_and_stop;
    if (errors == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Main sequence, reset held for 20 cycles
  initial begin
    repeat (20) @(negedge i_ref_clk);
    i_rst_b = 1;
    t_load;
    t_reloc;
    t_prog;
    report_and_stop;
  end
  // Whole run is well under a thousand cycles
  initial begin
    #20000;
    errors++;
    report_and_stop;
  end
endmodule
`default_nettype wire

// [verification/tape_terminal_model.sv]
// Behavioural terminal: tape reader and printer side.
`timescale 1ns/10ps
`default_nettype none
module tape_terminal_model #(
  parameter int GAP = 3,
  parameter int TX_DELAY = 6
) (
  input wire logic i_ref_clk, // Clock
  output logic o_rx_valid, // Char strobe
  output logic [7:0] o_rx_char, // Char
  input wire logic i_tx_valid, // Char offered
  input wire logic [7:0] i_tx_char, // Offered char
  output logic o_tx_ready // Char taken
);
  int cnt = 0;
  logic [7:0] last = 8'h00;
  initial begin
    o_rx_valid = 1'b0;
    o_rx_char = 8'h00;
    o_tx_ready = 1'b0;
  end
  // Slow pacing; line shows inverse value when idle
  task automatic send(input logic [7:0] c);
    @(negedge i_ref_clk);
    o_rx_valid = 1'b1;
    o_rx_char = c;
    @(negedge i_ref_clk);
    o_rx_valid = 1'b0;
    o_rx_char = ~c;
    repeat (GAP) @(negedge i_ref_clk);
  endtask
  // Printer takes a char only after a slow delay
  always @(negedge i_ref_clk) begin
    if (i_tx_valid !== 1'b1) begin
      cnt = 0;
      o_tx_ready = 1'b0;
    end else if (cnt == TX_DELAY) begin
      o_tx_ready = 1'b1;
      last = i_tx_char;
    end else begin
      cnt++;
    end
  end
endmodule
`default_nettype wire
